// ==== tb/qdc_host.sv ====
// Host model driving the chip select, serial clock and data pins.
// Assumes clk is the bench clock; each serial half period is four cycles.
`timescale 1ns/1ps
module qdc_host (
	input wire logic clk,
	output logic chip_select_n,
	output logic serial_clock,
	output logic serial_data_in
);
	// Idle: deselected, clock parked high
	initial begin
		chip_select_n = 1'b1;
		serial_clock = 1'b1;
		serial_data_in = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// One word, upper bit first; extra parks the clock low before deselect
	task automatic send(input logic [15:0] w, input logic extra);
		int i;
		@(negedge clk) chip_select_n <= 1'b0;
		repeat (6) @(negedge clk);
		for (i = 15; i >= 0; i--) begin
			serial_clock <= 1'b0;
			serial_data_in <= w[i];
			repeat (4) @(negedge clk);
			serial_clock <= 1'b1;
			repeat (4) @(negedge clk);
		end
		serial_clock <= !extra;
		repeat (4) @(negedge clk);
		chip_select_n <= 1'b1;
		repeat (4) @(negedge clk);
		// Released data no longer shows the last bit
		serial_data_in <= ~serial_data_in;
		serial_clock <= 1'b1;
	endtask : send
	// Chip select alone clocks the word while the serial clock is parked low
	task automatic send_cs(input logic [15:0] w);
		int i;
		@(negedge clk) serial_clock <= 1'b0;
		repeat (4) @(negedge clk);
		for (i = 15; i >= 0; i--) begin
			chip_select_n <= 1'b0;
			serial_data_in <= w[i];
			repeat (4) @(negedge clk);
			chip_select_n <= 1'b1;
			repeat (4) @(negedge clk);
		end
		serial_data_in <= ~serial_data_in;
		serial_clock <= 1'b1;
	endtask : send_cs
endmodule : qdc_host

// ==== tb/tb_top.sv ====
// Self-checking bench of the quad converter serial load control.
// Assumes the host model drives the link; bench drives strobes on falling clk.
`timescale 1ns/1ps
module tb_top;
	import qdc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic load_strobe_n = 1'b1;
	logic converter_reset_n = 1'b1;
	logic reset_code_select = 1'b0;
	logic chip_select_n, serial_clock, serial_data_in;
	logic [11:0] code_a, code_b, code_c, code_d;
	logic [15:0] shift_word;
	logic [11:0] ch [4];
	logic [11:0] model [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	always_comb ch = '{code_a, code_b, code_c, code_d};
	qdc_host qdc_host_i (.clk(clk), .chip_select_n(chip_select_n),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in));
	qdc_serial_load qdc_serial_load_i (.clk(clk), .rst_n(rst_n),
		.chip_select_n(chip_select_n), .serial_clock(serial_clock),
		.serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n),
		.converter_reset_n(converter_reset_n), .reset_code_select(reset_code_select),
		.channel_code_a(code_a), .channel_code_b(code_b), .channel_code_c(code_c),
		.channel_code_d(code_d), .shift_word(shift_word));
	////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n
	task automatic chk_all();
		int j;
		for (j = 0; j < 4; j++) chk({4'h0, ch[j]}, {4'h0, model[j]});
	endtask : chk_all
	// Link is idle here, so chip select stays high through the strobe
	task automatic load_pulse(input logic [15:0] w);
		@(negedge clk) load_strobe_n <= 1'b0;
		wait_n(8);
		load_strobe_n <= 1'b1;
		wait_n(8);
		model[w[15:14]] = w[11:0];
		chk_all();
	endtask : load_pulse
	////////////////////////////////////////////////////////////////
	// Converter reset: checked while low and after release
	task automatic conv_reset(input logic sel);
		logic [15:0] sw;
		int j;
		@(negedge clk) reset_code_select <= sel;
		wait_n(4);
		sw = shift_word;
		converter_reset_n <= 1'b0;
		wait_n(8);
		for (j = 0; j < 4; j++) model[j] = sel ? QDC_MID_SCALE : QDC_ZERO_SCALE;
		chk_all();
		chk(shift_word, sw);
		converter_reset_n <= 1'b1;
		wait_n(8);
		chk_all();
	endtask : conv_reset
	// Every address; channels hold while words shift past with load high
	task automatic test_load();
		logic [15:0] w;
		int k;
		for (k = 0; k < 4; k++) begin
			w = {k[1:0], 2'b11, 12'h5A3 ^ {3{k[3:0]}}};
			qdc_host_i.send(w, 1'b0);
			wait_n(6);
			chk(shift_word, w);
			chk_all();
			load_pulse(w);
		end
	endtask : test_load
	// Deselect with the clock low adds one shift of the held data bit
	task automatic test_extra();
		logic [15:0] w;
		logic [15:0] s;
		w = 16'h9C36;
		s = {w[14:0], w[0]};
		qdc_host_i.send(w, 1'b1);
		wait_n(6);
		chk(shift_word, s);
		load_pulse(s);
	endtask : test_extra
	// Serial clock held low; chip select alone shifts the word into C
	task automatic test_cs_only();
		logic [15:0] w;
		w = 16'hB5C9;
		qdc_host_i.send_cs(w);
		wait_n(6);
		chk(shift_word, w);
		load_pulse(w);
	endtask : test_cs_only
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// Hang guard well above the roughly 1700 cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		wait_n(8);
		rst_n <= 1'b1;
		wait_n(8);
		conv_reset(1'b1);
		test_load();
		test_extra();
		test_cs_only();
		conv_reset(1'b0);
		test_load();
		stop_test();
	end
endmodule : tb_top

// ==== verilog/qdc_pkg.sv ====
// Constants shared by the quad converter serial load control.
// Assumes a single clock domain at 100 MHz; pins are asynchronous to it.
package qdc_pkg;
	localparam int QDC_WORD_BITS = 16;
	localparam int QDC_CODE_BITS = 12;
	localparam int QDC_CHANNELS = 4;
	localparam int QDC_ADDR_HI_POS = 15;
	localparam int QDC_ADDR_LO_POS = 14;
	localparam int QDC_CODE_MSB_POS = 11;
	localparam logic [11:0] QDC_ZERO_SCALE = 12'h000;
	localparam logic [11:0] QDC_MID_SCALE = 12'h800;
	localparam logic [15:0] QDC_SHIFT_RESET = 16'h0000;
	localparam int QDC_FULL_SCALE_DIV = 4096;
	localparam logic [1:0] QDC_SYNC_RESET = 2'h0;
	// Synchronisers start at the idle pin level so no false edge follows reset
	localparam logic QDC_PIN_IDLE = 1'b1;
endpackage : qdc_pkg

// ==== verilog/qdc_serial_load.sv ====
// Serial input and channel register control of a quad 12-bit converter.
// Assumes pins are asynchronous to clk; each passes two flip-flops first.
//
// Overview of operation
// - 16-bit word: address, two unused, code
// - Address 00..11 selects channels A..D
// - 12-bit code sent most significant first
// - Load low: addressed register follows shift register
// - Load high: all channel registers hold while converter reset is high
// - Shift clock is chip select OR serial clock
// - Chip select rising with clock low shifts
// - Converter reset acts on clk edges, two edges late through its synchroniser
// - Reset forces 000 or 800 per select
// - Latched registers keep reset value after release
// - Reset leaves shift register unchanged
// - Code is straight binary over reference span
`timescale 1ns/1ps
module qdc_serial_load
	import qdc_pkg::*;
#(
	parameter int WORD_BITS = QDC_WORD_BITS,
	parameter int CODE_BITS = QDC_CODE_BITS,
	parameter int CHANNELS = QDC_CHANNELS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic load_strobe_n,
	input wire logic converter_reset_n,
	input wire logic reset_code_select,
	output logic [CODE_BITS-1:0] channel_code_a,
	output logic [CODE_BITS-1:0] channel_code_b,
	output logic [CODE_BITS-1:0] channel_code_c,
	output logic [CODE_BITS-1:0] channel_code_d,
	output logic [WORD_BITS-1:0] shift_word
);
	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic [1:0] rst_sync_reg;
	logic sys_rst_n;
	logic cs_n_s, sclk_s, sdi_s, load_n_s, conv_rst_n_s, rsel_s;

	// Block reset asserts at once and releases after two edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= QDC_SYNC_RESET;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign sys_rst_n = rst_sync_reg[1];

	qdc_sync u_sync_cs (.clk(clk), .rst_n(sys_rst_n), .async_in(chip_select_n),
		.sync_out(cs_n_s));
	qdc_sync u_sync_sclk (.clk(clk), .rst_n(sys_rst_n), .async_in(serial_clock),
		.sync_out(sclk_s));
	qdc_sync u_sync_sdi (.clk(clk), .rst_n(sys_rst_n), .async_in(serial_data_in),
		.sync_out(sdi_s));
	qdc_sync u_sync_load (.clk(clk), .rst_n(sys_rst_n), .async_in(load_strobe_n),
		.sync_out(load_n_s));
	qdc_sync u_sync_crst (.clk(clk), .rst_n(sys_rst_n), .async_in(converter_reset_n),
		.sync_out(conv_rst_n_s));
	qdc_sync u_sync_rsel (.clk(clk), .rst_n(sys_rst_n), .async_in(reset_code_select),
		.sync_out(rsel_s));

	////////////////////////////////////////////////////////////////////////
	// Combined shift clock and its rising edge
	logic shift_clk;
	logic shift_clk_reg;
	logic shift_rise;

	// Either pin may clock alone; a chip select rise with clock low also shifts
	assign shift_clk = cs_n_s | sclk_s;
	always_ff @(posedge clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			shift_clk_reg <= 1'b1;
		end else begin
			shift_clk_reg <= shift_clk;
		end
	end
	assign shift_rise = shift_clk & ~shift_clk_reg;

	////////////////////////////////////////////////////////////////////////
	// Serial shift register
	logic [WORD_BITS-1:0] shift_reg;

	// Data lags the clock path by nothing: both take two stages, so sdi_s is
	// the level present at the combined rising edge. Converter reset does not
	// touch this register, so a reset pulse keeps a half-sent word.
	always_ff @(posedge clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			shift_reg <= QDC_SHIFT_RESET;
		end else if (shift_rise) begin
			shift_reg <= {shift_reg[WORD_BITS-2:0], sdi_s};
		end
	end
	assign shift_word = shift_reg;

	////////////////////////////////////////////////////////////////////////
	// Channel registers
	logic [1:0] addr;
	logic [CODE_BITS-1:0] reset_code;
	logic [CODE_BITS-1:0] chan_reg [CHANNELS];

	// Upper address bit arrived first, so it sits at the top of the word
	assign addr = {shift_reg[QDC_ADDR_HI_POS], shift_reg[QDC_ADDR_LO_POS]};
	assign reset_code = rsel_s ? QDC_MID_SCALE : QDC_ZERO_SCALE;

	// Reset wins over load; latched registers then keep the reset code.
	// The code is straight binary, passed unchanged to the ladder. The
	// converter reset is seen two edges late, a cost of sampling the pin.
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		localparam logic [1:0] CH_ADDR = 2'(ch);
		always_ff @(posedge clk or negedge sys_rst_n) begin
			if (!sys_rst_n) begin
				chan_reg[ch] <= QDC_ZERO_SCALE;
			end else if (!conv_rst_n_s) begin
				chan_reg[ch] <= reset_code;
			end else if (!load_n_s && addr == CH_ADDR) begin
				chan_reg[ch] <= shift_reg[QDC_CODE_MSB_POS:0];
			end
		end
	end

	// Outputs are the channel flip-flops themselves
	assign channel_code_a = chan_reg[0];
	assign channel_code_b = chan_reg[1];
	assign channel_code_c = chan_reg[2];
	assign channel_code_d = chan_reg[3];

	////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_shift_one;
		@(posedge clk) disable iff (!sys_rst_n)
		shift_rise |=> shift_reg == {$past(shift_reg[WORD_BITS-2:0]), $past(sdi_s)};
	endproperty
	a_shift_one: assert property (p_shift_one) else $error("shift not one bit");

	property p_shift_hold;
		@(posedge clk) disable iff (!sys_rst_n)
		!shift_rise |=> $stable(shift_reg);
	endproperty
	a_shift_hold: assert property (p_shift_hold) else $error("shift moved");

	property p_cs_rise_shifts;
		@(posedge clk) disable iff (!sys_rst_n)
		(!sclk_s && !shift_clk_reg && cs_n_s) |=> shift_reg[0] == $past(sdi_s);
	endproperty
	a_cs_rise_shifts: assert property (p_cs_rise_shifts) else $error("cs edge lost");

	property p_reset_keeps_shift;
		@(posedge clk) disable iff (!sys_rst_n)
		(!conv_rst_n_s && !shift_rise) |=> $stable(shift_reg);
	endproperty
	a_reset_keeps_shift: assert property (p_reset_keeps_shift) else $error("reset hit shifter");

	property p_reset_code;
		@(posedge clk) disable iff (!sys_rst_n)
		!conv_rst_n_s |=> chan_reg[2] == ($past(rsel_s) ? 12'h800 : 12'h000);
	endproperty
	a_reset_code: assert property (p_reset_code) else $error("bad reset code");

	property p_load_hold;
		@(posedge clk) disable iff (!sys_rst_n)
		(load_n_s && conv_rst_n_s) |=> $stable(chan_reg[1]) && $stable(chan_reg[3]);
	endproperty
	a_load_hold: assert property (p_load_hold) else $error("latched reg moved");

	property p_load_follow;
		@(posedge clk) disable iff (!sys_rst_n)
		(!load_n_s && conv_rst_n_s && addr == 2'h1) |=> chan_reg[1] == $past(shift_reg[11:0]);
	endproperty
	a_load_follow: assert property (p_load_follow) else $error("B not transparent");

	property p_unselected_hold;
		@(posedge clk) disable iff (!sys_rst_n)
		(conv_rst_n_s && addr != 2'h0) |=> $stable(chan_reg[0]);
	endproperty
	a_unselected_hold: assert property (p_unselected_hold) else $error("A wrongly loaded");

	property p_follow_a;
		@(posedge clk) disable iff (!sys_rst_n)
		(!load_n_s && conv_rst_n_s && addr == 2'h0) |=> chan_reg[0] == $past(shift_reg[11:0]);
	endproperty
	a_follow_a: assert property (p_follow_a) else $error("A not transparent");

	property p_follow_c;
		@(posedge clk) disable iff (!sys_rst_n)
		(!load_n_s && conv_rst_n_s && addr == 2'h2) |=> chan_reg[2] == $past(shift_reg[11:0]);
	endproperty
	a_follow_c: assert property (p_follow_c) else $error("C not transparent");

	property p_follow_d;
		@(posedge clk) disable iff (!sys_rst_n)
		(!load_n_s && conv_rst_n_s && addr == 2'h3) |=> chan_reg[3] == $past(shift_reg[11:0]);
	endproperty
	a_follow_d: assert property (p_follow_d) else $error("D not transparent");

	// Channels A, B and D take the same reset code, not only C checked above
	property p_reset_all;
		@(posedge clk) disable iff (!sys_rst_n)
		!conv_rst_n_s |=> chan_reg[0] == ($past(rsel_s) ? QDC_MID_SCALE : QDC_ZERO_SCALE)
			&& chan_reg[1] == chan_reg[0] && chan_reg[3] == chan_reg[0];
	endproperty
	a_reset_all: assert property (p_reset_all) else $error("reset code not on all");

	property p_latched_after_reset;
		@(posedge clk) disable iff (!sys_rst_n)
		($rose(conv_rst_n_s) && load_n_s) |=> $stable(chan_reg[0]) && $stable(chan_reg[2]);
	endproperty
	a_latched_after_reset: assert property (p_latched_after_reset) else $error("lost reset code");

	property p_shift_idle_load;
		@(posedge clk) disable iff (!sys_rst_n)
		(!load_n_s && !shift_rise) |=> $stable(shift_reg);
	endproperty
	a_shift_idle_load: assert property (p_shift_idle_load) else $error("load moved shifter");

	// One pin edge must give exactly one shift, never a burst
	property p_rise_once;
		@(posedge clk) disable iff (!sys_rst_n)
		shift_rise |=> !shift_rise;
	endproperty
	a_rise_once: assert property (p_rise_once) else $error("double shift");
endmodule : qdc_serial_load

// ==== verilog/qdc_sync.sv ====
// Two flip-flop synchroniser for one asynchronous level.
// Assumes clk is the block clock and rst_n is already synchronised.
`timescale 1ns/1ps
module qdc_sync
	import qdc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;

	// First stage only feeds the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= QDC_PIN_IDLE;
			sync_out <= QDC_PIN_IDLE;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : qdc_sync
